// ==== gcd_chan.sv ====
// One channel: blanking/filter timer, fault detect and shutdown
`timescale 1ns/10ps
`default_nettype none
`include "gcd_regs.svh"
module gcd_chan (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic diag_en_i,
  input wire logic diag_rise_i,
  input wire logic cmd_on_i,
  input wire logic rearm_i,
  input wire logic latch_mode_i,
  input wire logic long_refresh_i,
  input wire gcd_pkg::gcd_fb_s fb_i,
  output logic shorted_o,
  output gcd_pkg::gcd_fault_e code_o,
  output logic fault_evt_o
);
  import gcd_pkg::*;
  gcd_state_e state_reg;
  logic [`GCD_CNT_W-1:0] tmr_reg;
  logic [20:0] retry_reg;
  logic cmd_on_d_reg;
  logic fault_on, fault_off, expired;
  gcd_fault_e off_code;

  assign expired = (tmr_reg == '0);
  assign fault_on = fb_i.above_short;
  assign fault_off = !fb_i.above_open;
  always_comb begin
    if (fb_i.below_gnd) begin
      off_code = GCD_FC_GND_E;
    end else begin
      off_code = GCD_FC_OPEN_E;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_on_d_reg <= 1'b0;
    end else begin
      cmd_on_d_reg <= cmd_on_i && !shorted_o;
    end
  end

  // Timer state: blank after each commanded edge, filter on threshold cross
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= GCD_ST_IDLE;
      tmr_reg <= '0;
    end else if (!diag_en_i) begin
      state_reg <= GCD_ST_IDLE;
      tmr_reg <= '0;
    end else if (diag_rise_i ||
                 ((cmd_on_i && !shorted_o) != cmd_on_d_reg)) begin
      state_reg <= GCD_ST_BLANK;
      tmr_reg <= (cmd_on_i && !shorted_o) ? `GCD_ON_BLANK_CNT
                                          : `GCD_OFF_BLANK_CNT;
    end else begin
      case (state_reg)
        GCD_ST_BLANK, GCD_ST_FILTER: begin
          if (expired) begin
            state_reg <= GCD_ST_STABLE;
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        GCD_ST_STABLE: begin
          if ((cmd_on_d_reg && fault_on) || (!cmd_on_d_reg && fault_off)) begin
            state_reg <= GCD_ST_FILTER;
            tmr_reg <= `GCD_FILTER_CNT;
          end
        end
        default: state_reg <= GCD_ST_IDLE;
      endcase
    end
  end

  // Sample feedback only once a timer has run out
  logic sample;
  assign sample = diag_en_i && expired &&
                  (state_reg == GCD_ST_BLANK || state_reg == GCD_ST_FILTER);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      code_o <= GCD_FC_NONE_E;
      fault_evt_o <= 1'b0;
    end else begin
      fault_evt_o <= 1'b0;
      if (sample && cmd_on_d_reg && fault_on) begin
        code_o <= GCD_FC_SHORT_E;
        fault_evt_o <= 1'b1;
      end else if (sample && !cmd_on_d_reg && fault_off) begin
        code_o <= off_code;
        fault_evt_o <= 1'b1;
      end
    end
  end

  // Shorted-load shutdown: latch-off or timed retry
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shorted_o <= 1'b0;
      retry_reg <= '0;
    end else if (!diag_en_i || rearm_i) begin
      shorted_o <= 1'b0;
      retry_reg <= '0;
    end else if (sample && cmd_on_d_reg && fault_on) begin
      shorted_o <= 1'b1;
      retry_reg <= long_refresh_i ? 21'(`GCD_REFRESH_LONG_CYC)
                                  : 21'(`GCD_REFRESH_SHORT_CYC);
    end else if (shorted_o && !latch_mode_i) begin
      if (retry_reg == '0) begin
        shorted_o <= 1'b0;
      end else begin
        retry_reg <= retry_reg - 1'b1;
      end
    end
  end
endmodule // gcd_chan
`default_nettype wire

// ==== gcd_load_model.sv ====
// Load and drain comparator model; kind uses the fault code encoding
`timescale 1ns/10ps
`default_nettype none
module gcd_load_model (
  input wire logic [5:0] gate_i,
  input wire gcd_pkg::gcd_codes_t kind_i,
  output logic [5:0] above_short_o,
  output logic [5:0] above_open_o,
  output logic [5:0] below_gnd_o
);
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      // A shorted load pulls the drain high whatever the gate does
      above_short_o[i] = kind_i[2*i+:2] == 2'h3;
      above_open_o[i] = above_short_o[i] ||
        (!gate_i[i] && kind_i[2*i+:2] == 2'h0);
      below_gnd_o[i] = !gate_i[i] && kind_i[2*i+:2] == 2'h2;
    end
  end
endmodule // gcd_load_model
`default_nettype wire

// ==== gcd_pkg.sv ====
// Types shared by the gate control block
`default_nettype none
package gcd_pkg;
  typedef enum logic [1:0] {
    GCD_FC_NONE_E  = 2'b00,
    GCD_FC_OPEN_E  = 2'b01,
    GCD_FC_GND_E   = 2'b10,
    GCD_FC_SHORT_E = 2'b11
  } gcd_fault_e;
  typedef enum logic [1:0] {
    GCD_ST_IDLE   = 2'b00,
    GCD_ST_BLANK  = 2'b01,
    GCD_ST_STABLE = 2'b10,
    GCD_ST_FILTER = 2'b11
  } gcd_state_e;
  // Comparator results for one channel
  typedef struct packed {
    logic above_short;
    logic above_open;
    logic below_gnd;
  } gcd_fb_s;
  typedef logic [11:0] gcd_codes_t;
endpackage
`default_nettype wire

// ==== gcd_regs.svh ====
// Timing and field constants for the six-channel gate control block
`ifndef GCD_REGS_SVH
`define GCD_REGS_SVH
`define GCD_NCH 6
`define GCD_CNT_W 16
`define GCD_ON_BLANK_CNT 16'h0064
`define GCD_OFF_BLANK_CNT 16'h0064
`define GCD_FILTER_CNT 16'h0032
`define GCD_REFRESH_SHORT_MS 10
`define GCD_REFRESH_LONG_MS 40
`define GCD_CLK_HZ 25000000
`define GCD_REFRESH_SHORT_CYC ((`GCD_CLK_HZ / 1000) * `GCD_REFRESH_SHORT_MS)
`define GCD_REFRESH_LONG_CYC ((`GCD_CLK_HZ / 1000) * `GCD_REFRESH_LONG_MS)
`define GCD_FC_NONE 2'h0
`define GCD_FC_OPEN 2'h1
`define GCD_FC_GND 2'h2
`define GCD_FC_SHORT 2'h3
`endif

// ==== gcd_top.sv ====
// Six-channel gate control and diagnostic top level
`timescale 1ns/10ps
`default_nettype none
`include "gcd_regs.svh"
module gcd_top (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic por_n_i,
  input wire logic soft_reset_enable_i,
  input wire logic output_enable_input_i,
  input wire logic [5:0] on_input_i,
  input wire logic gate_sel_wr_i,
  input wire logic [5:0] gate_sel_data_i,
  input wire logic [5:0] latch_mode_i,
  input wire logic [1:0] long_refresh_i,
  input wire logic [5:0] fb_above_short_i,
  input wire logic [5:0] fb_above_open_i,
  input wire logic [5:0] fb_below_gnd_i,
  output logic [5:0] gate_drive_out_o,
  output logic [5:0] gate_sel_o,
  output gcd_pkg::gcd_codes_t fault_codes_o,
  output logic fault_flag_n_o
);
  import gcd_pkg::*;
  // Pin inputs: three stages, change accepted when stages two and three agree
  localparam int NS = 3 + 6 + 18;
  logic [NS-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [NS-1:0] raw;
  assign raw = {por_n_i, soft_reset_enable_i, output_enable_input_i,
                on_input_i, fb_above_short_i, fb_above_open_i,
                fb_below_gnd_i};
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
    end
  end
  logic por_ok, en1, en2;
  logic [5:0] on_req, f_short, f_open, f_gnd;
  assign {por_ok, en1, en2, on_req, f_short, f_open, f_gnd} = filt_reg;

  logic diag_en, diag_en_d_reg, diag_rise;
  assign diag_en = por_ok && en1 && en2;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      diag_en_d_reg <= 1'b0;
    end else begin
      diag_en_d_reg <= diag_en;
    end
  end
  assign diag_rise = diag_en && !diag_en_d_reg;

  // Gate-select bits
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_sel_o <= '0;
    end else if (!en1 || !por_ok) begin
      gate_sel_o <= '0;
    end else if (gate_sel_wr_i) begin
      gate_sel_o <= gate_sel_data_i;
    end
  end

  // Re-arm on request release or output-enable off
  logic [5:0] req, req_d_reg, rearm;
  logic en2_d_reg;
  assign req = on_req | gate_sel_o;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_d_reg <= '0;
      en2_d_reg <= 1'b0;
    end else begin
      req_d_reg <= req;
      en2_d_reg <= en2;
    end
  end
  assign rearm = (req_d_reg & ~req) | {6{en2_d_reg && !en2}};

  logic [5:0] shorted, evt;
  gcd_fault_e codes [6];
  for (genvar c = 0; c < 6; c++) begin : g_ch
    gcd_fb_s fb;
    assign fb = {f_short[c], f_open[c], f_gnd[c]};
    gcd_chan u_chan (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .diag_en_i(diag_en),
      .diag_rise_i(diag_rise),
      .cmd_on_i(req[c]),
      .rearm_i(rearm[c]),
      .latch_mode_i(latch_mode_i[c]),
      .long_refresh_i(long_refresh_i[c / 3]),
      .fb_i(fb),
      .shorted_o(shorted[c]),
      .code_o(codes[c]),
      .fault_evt_o(evt[c])
    );
  end

  // Gate outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_drive_out_o <= '0;
    end else begin
      gate_drive_out_o <= {6{por_ok && en1 && en2}} & ~shorted & req;
    end
  end

  // Fault code latches: codes held until soft reset or power ok goes low
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_codes_o <= '0;
    end else if (!en1 || !por_ok) begin
      fault_codes_o <= '0;
    end else begin
      for (int c = 0; c < 6; c++) begin
        if (evt[c]) begin
          fault_codes_o[2*c +: 2] <= codes[c];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_flag_n_o <= 1'b1;
    end else if (!en1 || !por_ok) begin
      fault_flag_n_o <= 1'b1;
    end else if (|evt) begin
      fault_flag_n_o <= 1'b0;
    end
  end
endmodule // gcd_top
`default_nettype wire

// ==== gcd_top_checker.sv ====
// Port-level assertions for the gate control top level
`timescale 1ns/10ps
`default_nettype none
module gcd_top_checker (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic por_n_i,
  input wire logic soft_reset_enable_i,
  input wire logic output_enable_input_i,
  input wire logic [5:0] on_input_i,
  input wire logic gate_sel_wr_i,
  input wire logic [5:0] gate_sel_data_i,
  input wire logic [5:0] gate_drive_out_o,
  input wire logic [5:0] gate_sel_o,
  input wire gcd_pkg::gcd_codes_t fault_codes_o,
  input wire logic fault_flag_n_o
);
  wire sre = soft_reset_enable_i;
  wire oe = output_enable_input_i;
  wire ok = sre && oe && por_n_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Eight cycles covers the pin synchronisers and their agree filter
  property p_oe;
    !oe [*8] |-> gate_drive_out_o == 6'h00;
  endproperty
  a_oe: assert property (p_oe) else $error("gate on, oe low");
  property p_sr;
    !sre [*8] |-> gate_drive_out_o == 6'h00 && gate_sel_o == 6'h00 &&
      fault_codes_o == 12'h000 && fault_flag_n_o;
  endproperty
  a_sr: assert property (p_sr) else $error("soft reset");
  property p_wr;
    (sre && por_n_i) [*8] ##0 gate_sel_wr_i |=>
      gate_sel_o == $past(gate_sel_data_i);
  endproperty
  a_wr: assert property (p_wr) else $error("select write");
  property p_flag;
    $fell(fault_flag_n_o) |-> ##[0:2] fault_codes_o != 12'h000;
  endproperty
  a_flag: assert property (p_flag) else $error("flag no code");
  property p_stick;
    $rose(fault_flag_n_o) |-> !$past(sre);
  endproperty
  a_stick: assert property (p_stick) else $error("flag cleared");
  property p_diag;
    !oe [*8] |=> $stable(fault_codes_o) || fault_codes_o == 12'h000;
  endproperty
  a_diag: assert property (p_diag) else $error("diag on");
  property p_on;
    (ok && on_input_i[0] && fault_codes_o[1:0] != 2'h3) [*8] |->
      gate_drive_out_o[0];
  endproperty
  a_on: assert property (p_on) else $error("ch0 off");
  property p_sel;
    (ok && gate_sel_o[1] && fault_codes_o[3:2] != 2'h3) [*8] |->
      gate_drive_out_o[1];
  endproperty
  a_sel: assert property (p_sel) else $error("ch1 off");
endmodule // gcd_top_checker
bind gcd_top gcd_top_checker u_chk (.sys_clk_i, .sys_rst_i, .por_n_i,
  .soft_reset_enable_i, .output_enable_input_i, .on_input_i, .gate_sel_wr_i,
  .gate_sel_data_i, .gate_drive_out_o, .gate_sel_o, .fault_codes_o,
  .fault_flag_n_o);
`default_nettype wire

// ==== tb_gcd_top.sv ====
// Self-checking bench for the six-channel gate control block
`timescale 1ns/10ps
`default_nettype none
module tb_gcd_top;
  import gcd_pkg::*;
  typedef struct packed {
    logic [3:0] ctl;
    logic [5:0] on, sel, eg, es;
  } gcd_row_s;
  logic sys_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic por_n = 1'h0, sre = 1'h0, oe = 1'h0, wr = 1'h0;
  logic [5:0] on_in = 6'h00, wdata = 6'h00, lmode = 6'h00;
  logic [1:0] lref = 2'h0;
  gcd_codes_t kind = 12'h000;
  logic [5:0] fs, fo, fg, gate, sel;
  gcd_codes_t codes;
  logic flag_n;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // ctl holds power ok, soft enable, output enable, write select
  gcd_row_s rows [9] = '{'{4'hf, 6'h15, 6'h00, 6'h15, 6'h00},
    '{4'hf, 6'h00, 6'h2a, 6'h2a, 6'h2a}, '{4'hf, 6'h05, 6'h30, 6'h35, 6'h30},
    '{4'hd, 6'h3f, 6'h3f, 6'h00, 6'h3f}, '{4'he, 6'h00, 6'h00, 6'h3f, 6'h3f},
    '{4'hb, 6'h3f, 6'h3f, 6'h00, 6'h00}, '{4'he, 6'h00, 6'h00, 6'h00, 6'h00},
    '{4'h6, 6'h3f, 6'h00, 6'h00, 6'h00}, '{4'he, 6'h01, 6'h00, 6'h01, 6'h00}};
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  gcd_top dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .por_n_i(por_n),
    .soft_reset_enable_i(sre), .output_enable_input_i(oe),
    .on_input_i(on_in), .gate_sel_wr_i(wr), .gate_sel_data_i(wdata),
    .latch_mode_i(lmode), .long_refresh_i(lref), .fb_above_short_i(fs),
    .fb_above_open_i(fo), .fb_below_gnd_i(fg), .gate_drive_out_o(gate),
    .gate_sel_o(sel), .fault_codes_o(codes), .fault_flag_n_o(flag_n));
  gcd_load_model u_load (.gate_i(gate), .kind_i(kind), .above_short_o(fs),
    .above_open_o(fo), .below_gnd_o(fg));
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
      input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole run needs about 1900 cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("BAD %0t run too long", $time);
      results();
    end
  end
  initial begin
    cyc(6);
    sys_rst_i <= 1'h0;
    for (int i = 0; i < 9; i++) begin
      por_n <= rows[i].ctl[3];
      sre <= rows[i].ctl[2];
      oe <= rows[i].ctl[1];
      on_in <= rows[i].on;
      // Levels pass pin filters before any select write
      cyc(8);
      if (rows[i].ctl[0]) begin
        wr <= 1'h1;
        wdata <= rows[i].sel;
        cyc(1);
        wr <= 1'h0;
      end
      cyc(8);
      chk({6'h00, gate}, {6'h00, rows[i].eg}, "gate");
      chk({6'h00, sel}, {6'h00, rows[i].es}, "select");
      chk(codes, 12'h000, "codes");
      $display("row %0d done", i);
    end
    on_in <= 6'h00;
    cyc(200);
    kind <= 12'h024;
    cyc(30);
    chk(codes, 12'h000, "filter");
    cyc(200);
    chk(codes, 12'h024, "off faults");
    chk({11'h000, flag_n}, 12'h000, "flag");
    $display("off-state faults done");
    kind <= 12'h000;
    sre <= 1'h0;
    cyc(10);
    chk(codes, 12'h000, "cleared");
    chk({11'h000, flag_n}, 12'h001, "flag reset");
    sre <= 1'h1;
    cyc(200);
    $display("soft reset done");
    lmode <= 6'h01;
    lref <= 2'h2;
    kind <= 12'h303;
    cyc(10);
    on_in <= 6'h11;
    cyc(60);
    chk({6'h00, gate}, 12'h011, "blanking");
    cyc(150);
    chk({6'h00, gate}, 12'h000, "shut");
    chk(codes, 12'h303, "short codes");
    cyc(800);
    chk({6'h00, gate}, 12'h000, "held off");
    kind <= 12'h000;
    on_in <= 6'h10;
    cyc(10);
    on_in <= 6'h11;
    cyc(10);
    chk({6'h00, gate}, 12'h001, "re-armed");
    $display("shorted load done");
    // Output enable cycling re-arms the auto-retry channel too
    oe <= 1'h0;
    cyc(10);
    chk({6'h00, gate}, 12'h000, "oe off");
    oe <= 1'h1;
    cyc(10);
    chk({6'h00, gate}, 12'h011, "oe re-armed");
    $display("enable re-arm done");
    sys_rst_i <= 1'h1;
    cyc(2);
    chk({gate, sel}, 12'h000, "reset outputs");
    chk(codes, 12'h000, "reset codes");
    chk({11'h000, flag_n}, 12'h001, "reset flag");
    sys_rst_i <= 1'h0;
    cyc(8);
    chk({6'h00, gate}, 12'h011, "after reset");
    $display("mid-run reset done");
    results();
  end
endmodule // tb_gcd_top
`default_nettype wire
